// File: lpf_framer.sv
// Receive-side command decoder and data packet framer
module lpf_framer
  import lpf_pkg::*;
#(
  parameter int FIFO_DEPTH = lpf_pkg::LPF_FIFO_D
) (
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         reset_n,
  // Control packet in
  input  wire logic                         cmd_valid,
  input  wire logic [lpf_pkg::LPF_CMD_W-1:0] cmd_code,
  input  wire logic [lpf_pkg::LPF_CNT_W-1:0] cmd_count,
  output logic                              cmd_ready,
  // Data doublewords in
  input  wire logic                         dw_valid,
  input  wire logic [lpf_pkg::LPF_DW_W-1:0] dw_data,
  output logic                              dw_ready,
  // Decoded command out
  output logic                              dec_valid,
  output logic [lpf_pkg::LPF_CMD_W-1:0]     dec_code,
  output lpf_pkg::lpf_vc_t                  dec_vc,
  output logic                              dec_info,
  output logic                              dec_has_data,
  output logic                              dec_addr_ext,
  output logic                              dec_atomic,
  output logic                              dec_posted,
  output logic [lpf_pkg::LPF_DCNT_W-1:0]    dec_dwords,
  // Framed data out
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic [lpf_pkg::LPF_DW_W-1:0]      out_data,
  output logic [3:0]                        out_lane_en,
  output logic                              out_last,
  // Status
  output logic                              protocol_err,
  output logic                              length_err,
  output logic                              stall_warn
);

  //==========================================================
  // Declarations
  lpf_state_t          state_reg;         // Framing state
  logic [LPF_DCNT_W-1:0] remain_reg;      // Doublewords still owed
  logic [31:0]         mask_reg;          // Byte-write masks
  logic                byte_mode_reg;     // Current packet is byte write
  logic [LPF_STALL_W-1:0] gap_reg;        // Command-to-data gap
  logic                dec_valid_reg;
  logic [LPF_CMD_W-1:0] dec_code_reg;
  lpf_vc_t             dec_vc_reg;
  logic                dec_info_reg;
  logic                dec_has_data_reg;
  logic                dec_addr_ext_reg;
  logic                dec_atomic_reg;
  logic                dec_posted_reg;
  logic [LPF_DCNT_W-1:0] dec_dwords_reg;
  logic                perr_reg;
  logic                lerr_reg;
  logic                stall_reg;

  // Combinational decode
  lpf_vc_t             vc_next;
  logic                info_next;
  logic                data_next;
  logic                rsvd_next;
  logic                byte_wr_next;
  logic                posted_next;
  logic [LPF_DCNT_W-1:0] dwords_next;
  logic                cmd_take;
  logic                dw_take;
  logic                fifo_in_ready;
  logic                fifo_push;
  logic [LPF_DW_W+4:0] fifo_in;
  logic [LPF_DW_W+4:0] fifo_out;

  //==========================================================
  // Command decode of the code space
  always_comb begin
    vc_next      = LPF_VC_NONE;
    info_next    = 1'b0;
    data_next    = 1'b0;
    rsvd_next    = 1'b0;
    byte_wr_next = 1'b0;
    posted_next  = 1'b0;
    // Four-bit count caps a packet at 16 doublewords, one 64-byte block
    dwords_next  = LPF_DCNT_W'(cmd_count) + LPF_ONE;                        // RQ8 RQ11
    // Sized writes: bits 4:3 pick the write space, bits 5 and 2 are options
    if (cmd_code[LPF_CMD_W-2:LPF_CMD_W-3] == LPF_WR_MATCH[1:0]) begin       // RQ20
      data_next    = 1'b1;
      posted_next  = cmd_code[LPF_WR_POSTED_BIT];
      vc_next      = posted_next ? LPF_VC_POSTED : LPF_VC_NONPOST;
      byte_wr_next = !cmd_code[LPF_WR_DWORD_BIT];
    end else begin
      case (cmd_code)
        LPF_CMD_READ_RETURN: begin                                          // RQ2
          vc_next   = LPF_VC_RESPONSE;
          data_next = 1'b1;
        end
        LPF_CMD_TARGET_DONE: vc_next = LPF_VC_RESPONSE;                     // RQ2
        LPF_CMD_EXT_CREDIT:  info_next = 1'b1;                              // RQ3 RQ6
        LPF_CMD_SYNC_ERR:    info_next = 1'b1;                              // RQ5 RQ6
        LPF_CMD_BROADCAST:   vc_next = LPF_VC_POSTED;                       // RQ4
        LPF_CMD_FENCE:       vc_next = LPF_VC_POSTED;                       // RQ4
        LPF_CMD_ATOMIC: begin                                               // RQ1
          vc_next   = LPF_VC_NONPOST;
          data_next = 1'b1;
        end
        LPF_CMD_ADDR_EXT:    vc_next = LPF_VC_NONE;                         // RQ1
        LPF_CMD_RSVD_3536, LPF_CMD_RSVD_IO, LPF_CMD_RSVD_3B,
        LPF_CMD_RSVD_31, LPF_CMD_RSVD_32, LPF_CMD_RSVD_38,
        LPF_CMD_RSVD_39:     rsvd_next = 1'b1;                              // RQ7
        default: begin
          rsvd_next = (cmd_code == {LPF_CMD_RSVD_3536[5:1], 1'b1});         // RQ7
        end
      endcase
    end
  end

  //==========================================================
  // Handshakes: a new command waits until the previous one's data is in
  assign cmd_ready = (state_reg == LPF_ST_IDLE);                            // RQ16 RQ21
  assign cmd_take  = cmd_valid && cmd_ready;
  assign dw_ready  = (state_reg != LPF_ST_IDLE) && (state_reg == LPF_ST_MASK || fifo_in_ready);
  assign dw_take   = dw_valid && dw_ready;
  assign fifo_push = dw_take && (state_reg == LPF_ST_DATA);

  //==========================================================
  // Framing state and doubleword countdown
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg     <= LPF_ST_IDLE;
      remain_reg    <= '0;
      byte_mode_reg <= 1'b0;
    end else begin
      case (state_reg)
        LPF_ST_IDLE: begin
          if (cmd_take && data_next && !rsvd_next) begin
            remain_reg    <= dwords_next;                                   // RQ21
            byte_mode_reg <= byte_wr_next;
            // Byte write: mask doubleword precedes the data
            state_reg     <= byte_wr_next ? LPF_ST_MASK : LPF_ST_DATA;      // RQ13
          end
        end
        LPF_ST_MASK: begin
          if (dw_take) begin
            state_reg <= LPF_ST_DATA;                                       // RQ13
          end
        end
        LPF_ST_DATA: begin
          if (fifo_push) begin
            remain_reg <= remain_reg - LPF_ONE;                             // RQ21
            if (remain_reg == LPF_ONE) begin
              state_reg <= LPF_ST_IDLE;                                     // RQ16
            end
          end
        end
        default: state_reg <= LPF_ST_IDLE;
      endcase
    end
  end

  // Mask capture; all-zero masks are passed on, not rejected
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mask_reg <= '0;
    end else if (state_reg == LPF_ST_MASK && dw_take) begin
      mask_reg <= dw_data;                                                  // RQ14 RQ15
    end else if (fifo_push && byte_mode_reg) begin
      // Next doubleword's enables move down into the low nibble
      mask_reg <= mask_reg >> $bits(out_lane_en);                           // RQ14
    end
  end

  //==========================================================
  // Decoded command outputs, one-cycle pulse per non-reserved command
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dec_valid_reg    <= 1'b0;
      dec_code_reg     <= '0;
      dec_vc_reg       <= LPF_VC_NONE;
      dec_info_reg     <= 1'b0;
      dec_has_data_reg <= 1'b0;
      dec_addr_ext_reg <= 1'b0;
      dec_atomic_reg   <= 1'b0;
      dec_posted_reg   <= 1'b0;
      dec_dwords_reg   <= '0;
    end else begin
      dec_valid_reg <= cmd_take && !rsvd_next;
      if (cmd_take) begin
        dec_code_reg     <= cmd_code;
        dec_vc_reg       <= vc_next;
        dec_info_reg     <= info_next;
        dec_has_data_reg <= data_next;
        dec_addr_ext_reg <= (cmd_code == LPF_CMD_ADDR_EXT);                 // RQ1
        dec_atomic_reg   <= (cmd_code == LPF_CMD_ATOMIC);                   // RQ1
        dec_posted_reg   <= (vc_next == LPF_VC_POSTED);
        dec_dwords_reg   <= data_next ? dwords_next : '0;
      end
    end
  end

  //==========================================================
  // Error flags: reserved codes and illegal lengths
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      perr_reg <= 1'b0;
      lerr_reg <= 1'b0;
    end else begin
      perr_reg <= cmd_take && rsvd_next;                                    // RQ7
      // Byte writes carry at most eight data doublewords
      lerr_reg <= cmd_take && byte_wr_next && (dwords_next > LPF_MAX_BYTE_WR); // RQ13
    end
  end

  // Command-to-data gap watch; long gaps raise the stall warning flag
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      gap_reg   <= '0;
      stall_reg <= 1'b0;
    end else if (state_reg == LPF_ST_IDLE || dw_take) begin
      gap_reg   <= '0;
      stall_reg <= 1'b0;
    end else if (gap_reg == LPF_STALL_W'(LPF_STALL_CYCLES)) begin
      // Tells the forwarding side to pair command and data back to back
      stall_reg <= 1'b1;                                                    // RQ17 RQ18 RQ19
    end else begin
      gap_reg <= gap_reg + 1'b1;
    end
  end

  assign dec_valid    = dec_valid_reg;
  assign dec_code     = dec_code_reg;
  assign dec_vc       = dec_vc_reg;
  assign dec_info     = dec_info_reg;
  assign dec_has_data = dec_has_data_reg;
  assign dec_addr_ext = dec_addr_ext_reg;
  assign dec_atomic   = dec_atomic_reg;
  assign dec_posted   = dec_posted_reg;
  assign dec_dwords   = dec_dwords_reg;
  assign protocol_err = perr_reg;
  assign length_err   = lerr_reg;
  assign stall_warn   = stall_reg;

  //==========================================================
  // Data FIFO: lanes kept natural, lane enables from masks on byte writes, all set otherwise
  assign fifo_in = {(remain_reg == LPF_ONE),
                    (byte_mode_reg ? mask_reg[3:0] : 4'hF),                 // RQ9 RQ14
                    dw_data};                                               // RQ10 RQ12

  lpf_fifo #(
    .WIDTH (LPF_DW_W + 5),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out)
  );

  assign out_data    = fifo_out[LPF_DW_W-1:0];
  assign out_lane_en = fifo_out[LPF_DW_W+3:LPF_DW_W];
  assign out_last    = fifo_out[LPF_DW_W+4];

endmodule : lpf_framer

// File: lpf_pkg.sv
// Package: constants and types for the link packet framer
//==========================================================
// Summary of operation
// RQ1: Six-bit code; decode atomic and address-extension prefix.
// RQ2: Read return and completion go in response channel.
// RQ3: Extended credit info covers sets 0-7, no channel.
// RQ4: Fence and broadcast travel in posted channel.
// RQ5: All-ones code is sync/error info packet.
// RQ6: Info packets use no buffer, no channel.
// RQ7: Reserved codes raise a protocol error flag.
// RQ8: Data packet 4-64 bytes, count from command.
// RQ9: Bytes keep natural lanes, short data padded.
// RQ10: Read data lowest doubleword first, ascending.
// RQ11: Response data never wraps its 64-byte block.
// RQ12: Doubleword write carries 1-16 ascending doublewords.
// RQ13: Byte write sends mask doubleword, then 1-8.
// RQ14: Always 32 mask bits; mask bit n enables byte n.
// RQ15: Zero masks accepted; only messages omit data.
// RQ16: Data belongs to its command, no interleave.
// RQ17: Do not hold data long after command.
// RQ18: Slow-link tunnel defers command until data ready.
// RQ19: Bridge sends command and data back to back.
// RQ20: Sized writes 001xxx/101xxx; bit5 posted, bit2 size.
// RQ21: Count data doublewords down before next command.
package lpf_pkg;

  //==========================================================
  // Widths
  localparam int LPF_CMD_W   = 6;
  localparam int LPF_DW_W    = 32;
  localparam int LPF_CNT_W   = 4;
  localparam int LPF_DCNT_W  = 5;
  localparam int LPF_FIFO_D  = 4;

  //==========================================================
  // Command codes
  localparam logic [5:0] LPF_CMD_READ_RETURN = 6'h30;
  localparam logic [5:0] LPF_CMD_TARGET_DONE = 6'h33;
  localparam logic [5:0] LPF_CMD_EXT_CREDIT  = 6'h37;
  localparam logic [5:0] LPF_CMD_BROADCAST   = 6'h3A;
  localparam logic [5:0] LPF_CMD_FENCE       = 6'h3C;
  localparam logic [5:0] LPF_CMD_ATOMIC      = 6'h3D;
  localparam logic [5:0] LPF_CMD_ADDR_EXT    = 6'h3E;
  localparam logic [5:0] LPF_CMD_SYNC_ERR    = 6'h3F;
  localparam logic [5:0] LPF_CMD_RSVD_3536   = 6'h34;
  localparam logic [5:0] LPF_CMD_RSVD_IO     = 6'h36;
  localparam logic [5:0] LPF_CMD_RSVD_3B     = 6'h3B;
  localparam logic [5:0] LPF_CMD_RSVD_31     = 6'h31;
  localparam logic [5:0] LPF_CMD_RSVD_32     = 6'h32;
  localparam logic [5:0] LPF_CMD_RSVD_38     = 6'h38;
  localparam logic [5:0] LPF_CMD_RSVD_39     = 6'h39;

  // Sized-write field positions
  localparam int LPF_WR_POSTED_BIT = 5;
  localparam int LPF_WR_DWORD_BIT  = 2;
  localparam logic [2:0] LPF_WR_MATCH = 3'h1;

  // Data-length limits
  localparam logic [4:0] LPF_MAX_DWORD_WR = 5'h10;
  localparam logic [4:0] LPF_MAX_BYTE_WR  = 5'h08;
  localparam logic [4:0] LPF_ONE          = 5'h01;

  // Longest command-to-data gap before a stall is flagged
  localparam int LPF_STALL_NS     = 2000;
  localparam int LPF_CLK_NS       = 25;
  localparam int LPF_STALL_CYCLES = LPF_STALL_NS / LPF_CLK_NS;
  localparam int LPF_STALL_W      = 8;

  //==========================================================
  // Channel classes
  typedef enum logic [1:0] {
    LPF_VC_NONE     = 2'b00,
    LPF_VC_POSTED   = 2'b01,
    LPF_VC_NONPOST  = 2'b10,
    LPF_VC_RESPONSE = 2'b11
  } lpf_vc_t;

  // Receive framing states
  typedef enum logic [1:0] {
    LPF_ST_IDLE = 2'b00,
    LPF_ST_MASK = 2'b01,
    LPF_ST_DATA = 2'b10
  } lpf_state_t;

endpackage : lpf_pkg

// File: lpf_fifo.sv
// Small flop FIFO with valid/ready on both sides
module lpf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];   // Storage
  logic [AW-1:0]    wr_ptr_reg;        // Write index
  logic [AW-1:0]    rd_ptr_reg;        // Read index
  logic [AW:0]      count_reg;         // Occupancy
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  //==========================================================
  // Storage write
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : lpf_fifo

// File: lpf_framer_asserts.sv
// Checker: decode and framing properties of the link packet framer
module lpf_framer_asserts
  import lpf_pkg::*;
(
  // Clock and reset
  input wire logic                          sys_clk,
  input wire logic                          reset_n,
  // Command and data handshakes
  input wire logic                          cmd_valid,
  input wire logic [lpf_pkg::LPF_CMD_W-1:0] cmd_code,
  input wire logic                          cmd_ready,
  input wire logic                          dw_ready,
  // Decoded results
  input wire logic                          dec_valid,
  input wire lpf_pkg::lpf_vc_t              dec_vc,
  input wire logic                          dec_info,
  input wire logic                          dec_atomic,
  input wire logic                          dec_addr_ext,
  input wire logic                          dec_posted,
  input wire logic                          protocol_err
);
  //==========================================================
  // Helpers
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic tk;  // Command taken this edge
  logic rsv; // Reserved upper code point
  assign tk  = cmd_valid && cmd_ready;
  assign rsv = cmd_code inside {6'h31, 6'h32, 6'h34, 6'h35, 6'h36, 6'h38, 6'h39, 6'h3B};

  //==========================================================
  // Properties
  property p_rsv;
    tk && rsv |=> protocol_err && !dec_valid;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code not flagged");
  property p_legal;
    tk && !rsv && cmd_code[5:4] == 2'b11 |=> dec_valid && !protocol_err;
  endproperty
  a_legal: assert property (p_legal) else $error("legal code not decoded");
  property p_resp;
    tk && (cmd_code == LPF_CMD_READ_RETURN || cmd_code == LPF_CMD_TARGET_DONE) |=> dec_vc == LPF_VC_RESPONSE;
  endproperty
  a_resp: assert property (p_resp) else $error("response class wrong");
  property p_info;
    tk && (cmd_code == LPF_CMD_EXT_CREDIT || cmd_code == LPF_CMD_SYNC_ERR) |=> dec_info && dec_vc == LPF_VC_NONE;
  endproperty
  a_info: assert property (p_info) else $error("info packet misclassed");
  property p_post;
    tk && (cmd_code == LPF_CMD_FENCE || cmd_code == LPF_CMD_BROADCAST) |=> dec_vc == LPF_VC_POSTED;
  endproperty
  a_post: assert property (p_post) else $error("posted class wrong");
  property p_atom;
    tk && cmd_code == LPF_CMD_ATOMIC |=> dec_atomic && dec_vc == LPF_VC_NONPOST;
  endproperty
  a_atom: assert property (p_atom) else $error("atomic decode wrong");
  property p_ext;
    tk && cmd_code == LPF_CMD_ADDR_EXT |=> dec_addr_ext && !dec_info;
  endproperty
  a_ext: assert property (p_ext) else $error("address prefix decode wrong");
  property p_wr_p;
    tk && cmd_code[5:3] == 3'h5 |=> dec_posted && dec_vc == LPF_VC_POSTED;
  endproperty
  a_wr_p: assert property (p_wr_p) else $error("posted write decode wrong");
  property p_wr_np;
    tk && cmd_code[5:3] == 3'h1 |=> !dec_posted && dec_vc == LPF_VC_NONPOST;
  endproperty
  a_wr_np: assert property (p_wr_np) else $error("nonposted write decode wrong");
  property p_excl;
    tk && (cmd_code[4:3] == 2'h1 || cmd_code == LPF_CMD_READ_RETURN || cmd_code == LPF_CMD_ATOMIC) |=> !cmd_ready;
  endproperty
  a_excl: assert property (p_excl) else $error("command taken while data owed");
  property p_mask;
    tk && cmd_code[4:2] == 3'h2 |=> dw_ready && !cmd_ready;
  endproperty
  a_mask: assert property (p_mask) else $error("mask doubleword not accepted first");
endmodule : lpf_framer_asserts

// File: lpf_peer.sv
// Peer link model: offers commands and data, drains framed words
module lpf_peer
  import lpf_pkg::*;
(
  // Clock
  input wire logic                      sys_clk,
  // Command channel
  output logic                          cmd_valid,
  output logic [lpf_pkg::LPF_CMD_W-1:0] cmd_code,
  output logic [lpf_pkg::LPF_CNT_W-1:0] cmd_count,
  input wire logic                      cmd_ready,
  // Data channel
  output logic                          dw_valid,
  output logic [lpf_pkg::LPF_DW_W-1:0]  dw_data,
  input wire logic                      dw_ready,
  // Drain side
  output logic                          out_ready
);
  logic hold = 1'b0; // Drain stall, set by the bench
  assign out_ready = !hold;
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = '0;
    cmd_count = '0;
    dw_valid  = 1'b0;
    dw_data   = '0;
  end
  //==========================================================
  // Command offer; released lines show the inverse, not stale values
  task automatic send_cmd(input logic [5:0] code, input logic [3:0] cnt);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_code  = code;
    cmd_count = cnt;
    @(posedge sys_clk);
    while (!cmd_ready) @(posedge sys_clk);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_code  = ~code;
    cmd_count = ~cnt;
  endtask : send_cmd
  //==========================================================
  // Data word offer; released lines show the inverse, not stale values
  task automatic send_dw(input logic [31:0] d);
    @(negedge sys_clk);
    dw_valid = 1'b1;
    dw_data  = d;
    @(posedge sys_clk);
    while (!dw_ready) @(posedge sys_clk);
    @(negedge sys_clk);
    dw_valid = 1'b0;
    dw_data  = ~d;
  endtask : send_dw
endmodule : lpf_peer

// File: lpf_framer_tb.sv
// Bench for the link packet framer: decode, framing, buffering, stall watch
module lpf_framer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lpf_pkg::*;
  //==========================================================
  // Signals
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid, cmd_ready, dw_valid, dw_ready, out_ready, out_valid, out_last;
  logic dec_valid, dec_info, dec_has_data, dec_addr_ext, dec_atomic, dec_posted;
  logic protocol_err, length_err, stall_warn;
  logic [5:0]  cmd_code, dec_code;
  logic [3:0]  cmd_count, out_lane_en;
  logic [4:0]  dec_dwords;
  logic [31:0] dw_data, out_data;
  lpf_vc_t     dec_vc;
  logic [36:0] got[$]; // Drained {last, lanes, data}
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  lpf_framer lpf_framer_i (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_count(cmd_count), .cmd_ready(cmd_ready), .dw_valid(dw_valid), .dw_data(dw_data), .dw_ready(dw_ready),
    .dec_valid(dec_valid), .dec_code(dec_code), .dec_vc(dec_vc), .dec_info(dec_info), .dec_has_data(dec_has_data),
    .dec_addr_ext(dec_addr_ext), .dec_atomic(dec_atomic), .dec_posted(dec_posted), .dec_dwords(dec_dwords),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_lane_en(out_lane_en),
    .out_last(out_last), .protocol_err(protocol_err), .length_err(length_err), .stall_warn(stall_warn));
  lpf_peer lpf_peer_i (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_count(cmd_count),
    .cmd_ready(cmd_ready), .dw_valid(dw_valid), .dw_data(dw_data), .dw_ready(dw_ready), .out_ready(out_ready));
  // Monitor of drained words
  always @(posedge sys_clk) if (reset_n && out_valid && out_ready) got.push_back({out_last, out_lane_en, out_data});
  // Run takes about 230 cycles; ceiling leaves wide margin for slow answers
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  //==========================================================
  // Compare and closing tasks
  task automatic chk_val(input string what, input logic [36:0] exp, input logic [36:0] act);
    checked++;
    if (act !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, act);
    end
  endtask : chk_val
  task automatic chk_flag(input string what, input logic exp, input logic act);
    chk_val(what, {36'h0, exp}, {36'h0, act});
  endtask : chk_flag
  // Lanes: low nibble for the first word, high nibble for the rest
  task automatic expect_words(input int n, input logic [7:0] lane, input logic [31:0] base);
    repeat (40) if (got.size() < n) @(posedge sys_clk);
    chk_val("word count", 37'(n), 37'(got.size()));
    for (int i = 0; i < got.size(); i++)
      chk_val("framed word", {i == n - 1, (i == 0) ? lane[3:0] : lane[7:4], base + i}, got[i]);
    got.delete();
  endtask : expect_words
  task automatic end_sim;
    $display("checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  //==========================================================
  // Scenarios
  task automatic test_codes;
    logic [5:0] c[16] = '{6'h30, 6'h33, 6'h37, 6'h3A, 6'h3C, 6'h3D, 6'h3E, 6'h3F,
                          6'h31, 6'h32, 6'h34, 6'h35, 6'h36, 6'h38, 6'h39, 6'h3B};
    logic [3:0] e[8] = '{4'hB, 4'h3, 4'h4, 4'h1, 4'h1, 4'hA, 4'h0, 4'h4}; // {data, info, class}
    for (int i = 0; i < 16; i++) begin
      lpf_peer_i.send_cmd(c[i], 4'h0);
      chk_flag("error flag", i > 7, protocol_err);
      chk_flag("decode pulse", i < 8, dec_valid);
      if (i < 8) chk_val("decode class", e[i], {dec_has_data, dec_info, dec_vc});
      if (i < 8) chk_val("decode code", 37'(c[i]), 37'(dec_code));
      if (i < 8 && e[i][3]) begin
        lpf_peer_i.send_dw(32'h1234_5678);
        expect_words(1, 8'hFF, 32'h1234_5678);
      end
    end
    $display("test_codes done");
  endtask : test_codes
  task automatic test_fill;
    lpf_peer_i.hold = 1'b1;
    lpf_peer_i.send_cmd(6'h2C, 4'hF);
    chk_flag("posted", 1'b1, dec_posted);
    chk_val("dword count", 37'h10, {32'h0, dec_dwords});
    fork
      for (int i = 0; i < 16; i++) lpf_peer_i.send_dw(32'hA000_0000 + i);
      begin
        repeat (30) @(negedge sys_clk);
        chk_flag("full refuses", 1'b0, dw_ready);
        chk_flag("no command while owed", 1'b0, cmd_ready);
        lpf_peer_i.hold = 1'b0;
      end
    join
    expect_words(16, 8'hFF, 32'hA000_0000);
    $display("test_fill done");
  endtask : test_fill
  task automatic test_bytes(input logic [3:0] m);
    lpf_peer_i.send_cmd(6'h08, 4'h1);
    chk_flag("nonposted", 1'b0, dec_posted);
    lpf_peer_i.send_dw({24'hFF_FFFF, ~m, m}); // Mask word leads
    lpf_peer_i.send_dw(32'hB000_0000);
    lpf_peer_i.send_dw(32'hB000_0001);
    expect_words(2, {~m, m}, 32'hB000_0000);
    $display("test_bytes done");
  endtask : test_bytes
  task automatic test_stall;
    lpf_peer_i.send_cmd(6'h2D, 4'h0);
    repeat (60) @(negedge sys_clk);
    chk_flag("early warning", 1'b0, stall_warn);
    repeat (40) @(negedge sys_clk);
    chk_flag("stall warning", 1'b1, stall_warn);
    lpf_peer_i.send_dw(32'hC000_0000);
    expect_words(1, 8'hFF, 32'hC000_0000);
    chk_flag("warning cleared", 1'b0, stall_warn);
    $display("test_stall done");
  endtask : test_stall
  task automatic test_length;
    lpf_peer_i.send_cmd(6'h08, 4'h8);
    chk_flag("length error", 1'b1, length_err);
    reset_n = 1'b0; // Mid-run reset clears the owed packet
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    chk_flag("idle after reset", 1'b1, cmd_ready);
    $display("test_length done");
  endtask : test_length
  //==========================================================
  // Main sequence
  initial begin
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    test_codes();
    test_fill();
    test_bytes(4'h5);
    test_bytes(4'h0);
    test_stall();
    test_length();
    end_sim();
  end
endmodule : lpf_framer_tb

bind lpf_framer lpf_framer_asserts lpf_framer_asserts_i (.sys_clk(sys_clk), .reset_n(reset_n),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready), .dw_ready(dw_ready),
  .dec_valid(dec_valid), .dec_vc(dec_vc), .dec_info(dec_info), .dec_atomic(dec_atomic),
  .dec_addr_ext(dec_addr_ext), .dec_posted(dec_posted), .protocol_err(protocol_err));
